// ===== sdc_pkg.sv
`default_nettype none
package sdc_pkg;
    localparam int ADDR_W = 11;
    localparam int COL_W = 8;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int BYTES = 2;
    localparam int BANKS = 2;
    localparam int MEM_AW = 1 + COL_W;
    localparam int MEM_DEPTH = 512;
    localparam int AUTO_PRECHARGE_BIT = 10;
    // mode register fields
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BL_W = 3;
    localparam int MODE_BT_BIT = 3;
    localparam int MODE_CL_LSB = 4;
    localparam int MODE_CL_W = 3;
    localparam logic [MODE_CL_W-1:0] CL_THREE = 3'h3;
    localparam logic [MODE_BL_W-1:0] BL_ONE = 3'h0;
    localparam logic [MODE_BL_W-1:0] BL_TWO = 3'h1;
    localparam logic [MODE_BL_W-1:0] BL_FOUR = 3'h2;
    localparam logic [MODE_BL_W-1:0] BL_EIGHT = 3'h3;
    localparam logic [MODE_BL_W-1:0] BL_PAGE = 3'h7;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int POWERUP_PAUSE_NS = 200000;
    localparam int POWERUP_PAUSE_CYC = (POWERUP_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MODE_SET_RECOVERY_NS = 50;
    localparam int MODE_SET_RECOVERY_CYC = (MODE_SET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRECHARGE_NS = 25;
    localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFRESH_NS = 75;
    localparam int REFRESH_CYC = (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_REFRESH_COUNT = 8;
    localparam int TIMER_W = 14;
    localparam int RCV_W = 4;
    localparam int REFRESH_CNT_W = 8;
    // command code is {row strobe, column strobe, write strobe}
    typedef enum logic [2:0] {
        CMD_MODE_SET = 3'b000,
        CMD_AUTO_REFRESH = 3'b001,
        CMD_PRECHARGE = 3'b010,
        CMD_ACTIVATE = 3'b011,
        CMD_WRITE = 3'b100,
        CMD_READ = 3'b101,
        CMD_BURST_STOP = 3'b110,
        CMD_IDLE = 3'b111
    } sdc_cmd_t;
    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_DOWN = 2'b01,
        PWR_SUSPEND = 2'b10,
        PWR_SELF_REFRESH = 2'b11
    } sdc_pwr_t;
endpackage
`default_nettype wire

// ===== sdc_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sdc_if
    import sdc_pkg::*;
();
    logic chipSelectN;
    logic rowStrobeN;
    logic columnStrobeN;
    logic writeStrobeN;
    logic clockGateIn;
    logic bankSelect;
    logic [ADDR_W-1:0] addressLines;
    logic upperByteMask;
    logic lowerByteMask;
    logic [DATA_W-1:0] hostData;
    logic [BYTES-1:0] hostOe;
    logic [DATA_W-1:0] devData;
    logic [BYTES-1:0] devOe;
    logic [DATA_W-1:0] dataLines;

    // an undriven lane reads as zero
    for (genvar b = 0; b < BYTES; b++) begin : gLane
        assign dataLines[b*BYTE_W +: BYTE_W] = hostOe[b] ? hostData[b*BYTE_W +: BYTE_W]
            : devOe[b] ? devData[b*BYTE_W +: BYTE_W] : 8'h00;
    end

    modport ctrl (
        output chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN, clockGateIn, bankSelect,
        output addressLines, upperByteMask, lowerByteMask, hostData, hostOe,
        input dataLines
    );
    modport dram (
        input chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN, clockGateIn, bankSelect,
        input addressLines, upperByteMask, lowerByteMask, dataLines,
        output devData, devOe
    );
endinterface // sdc_if
`default_nettype wire

// ===== sdc_wait_timer.sv
`timescale 1ns/100ps
`default_nettype none
module sdc_wait_timer
    import sdc_pkg::*;
#(
    parameter logic [TIMER_W-1:0] RESET_COUNT = 14'h0000
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic load,
    input wire logic [TIMER_W-1:0] loadValue,
    output logic done
);
    logic [TIMER_W-1:0] count_q;
    logic [TIMER_W-1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = loadValue;
        end else if (count_q != '0) begin
            count_d = count_q - 1'b1;
        end
    end

    // counting starts at reset so the power-up pause needs no start strobe
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            count_q <= RESET_COUNT;
        end else if (clkEn) begin
            count_q <= count_d;
        end
    end

    assign done = (count_q == '0);
endmodule // sdc_wait_timer
`default_nettype wire

// ===== sdc_ctrl_end.sv
`timescale 1ns/100ps
`default_nettype none
module sdc_ctrl_end
    import sdc_pkg::*;
#(
    parameter int PAUSE_CYC = POWERUP_PAUSE_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    sdc_if.ctrl mem,
    input wire logic [ADDR_W-1:0] modeValue,
    input wire logic reqValid,
    input wire sdc_cmd_t reqCmd,
    input wire logic reqBank,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic userCke,
    input wire logic [BYTES-1:0] userMask,
    input wire logic [BYTES-1:0] userDrive,
    input wire logic [DATA_W-1:0] userWdata,
    output logic reqReady,
    output logic initDone,
    output logic [DATA_W-1:0] readData
);
    typedef enum logic [2:0] {
        H_PAUSE = 3'b000,
        H_PRECHARGE = 3'b001,
        H_MODE_SET = 3'b010,
        H_REFRESH = 3'b011,
        H_WAIT = 3'b100,
        H_READY = 3'b101
    } sdc_host_st_t;

    typedef struct packed {
        sdc_host_st_t st;
        sdc_host_st_t after;
        logic [3:0] refreshes;
        logic csN;
        sdc_cmd_t cmd;
        logic cke;
        logic [BYTES-1:0] mask;
        logic bank;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [BYTES-1:0] oe;
        logic reqReady;
        logic initDone;
        logic [DATA_W-1:0] readData;
    } sdc_host_state_t;

    // idle command, masks and clock gate high from the first cycle
    localparam sdc_host_state_t HOST_RESET = '{st: H_PAUSE, after: H_PAUSE, cmd: CMD_IDLE,
        cke: 1'b1, mask: 2'h3, default: '0};

    sdc_host_state_t state_q;
    sdc_host_state_t state_d;
    logic tLoad;
    logic [TIMER_W-1:0] tValue;
    logic tDone;

    sdc_wait_timer #(
        .RESET_COUNT(TIMER_W'(PAUSE_CYC))
    ) uTimer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .load(tLoad),
        .loadValue(tValue),
        .done(tDone)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        tLoad = 1'b0;
        tValue = '0;
        state_d.cmd = CMD_IDLE;
        state_d.csN = 1'b0;
        state_d.readData = mem.dataLines;
        unique case (state_q.st)
            H_PAUSE: begin
                if (tDone) begin
                    state_d.st = H_PRECHARGE;
                end
            end
            H_PRECHARGE: begin
                state_d.cmd = CMD_PRECHARGE;
                state_d.addr = '0;
                state_d.addr[AUTO_PRECHARGE_BIT] = 1'b1;
                tLoad = 1'b1;
                tValue = TIMER_W'(PRECHARGE_CYC);
                state_d.st = H_WAIT;
                state_d.after = H_MODE_SET;
            end
            H_MODE_SET: begin
                state_d.cmd = CMD_MODE_SET;
                state_d.addr = modeValue;
                tLoad = 1'b1;
                tValue = TIMER_W'(MODE_SET_RECOVERY_CYC);
                state_d.st = H_WAIT;
                state_d.after = H_REFRESH;
                state_d.refreshes = '0;
            end
            H_REFRESH: begin
                state_d.cmd = CMD_AUTO_REFRESH;
                state_d.refreshes = state_q.refreshes + 1'b1;
                tLoad = 1'b1;
                tValue = TIMER_W'(REFRESH_CYC);
                state_d.st = H_WAIT;
                state_d.after = (state_q.refreshes == 4'(INIT_REFRESH_COUNT - 1)) ? H_READY : H_REFRESH;
            end
            H_WAIT: begin
                if (tDone) begin
                    state_d.st = state_q.after;
                end
            end
            H_READY: begin
                state_d.cke = userCke;
                state_d.mask = userMask;
                state_d.oe = userDrive;
                state_d.wdata = userWdata;
                if (reqValid && state_q.reqReady) begin
                    state_d.cmd = reqCmd;
                    state_d.bank = reqBank;
                    state_d.addr = reqAddr;
                    if (reqCmd == CMD_MODE_SET) begin
                        tLoad = 1'b1;
                        tValue = TIMER_W'(MODE_SET_RECOVERY_CYC);
                        state_d.st = H_WAIT;
                        state_d.after = H_READY;
                    end
                end
            end
        endcase
        state_d.reqReady = (state_d.st == H_READY);
        state_d.initDone = state_q.initDone | (state_d.st == H_READY);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= HOST_RESET;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins straight from the state register
    assign mem.chipSelectN = state_q.csN;
    assign mem.rowStrobeN = state_q.cmd[2];
    assign mem.columnStrobeN = state_q.cmd[1];
    assign mem.writeStrobeN = state_q.cmd[0];
    assign mem.clockGateIn = state_q.cke;
    assign mem.bankSelect = state_q.bank;
    assign mem.addressLines = state_q.addr;
    assign mem.upperByteMask = state_q.mask[1];
    assign mem.lowerByteMask = state_q.mask[0];
    assign mem.hostData = state_q.wdata;
    assign mem.hostOe = state_q.oe;
    assign reqReady = state_q.reqReady;
    assign initDone = state_q.initDone;
    assign readData = state_q.readData;
endmodule // sdc_ctrl_end
`default_nettype wire

// ===== sdc_dram_end.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - row on eleven lines, column on eight
// - bank select picks activated or accessed bank
// - chip select high ignores new commands
// - three strobes sampled each rising edge
// - read mask tristates byte two cycles later
// - write mask blocks byte same cycle
// - clock gate low: power-down, suspend, self-refresh
// - mode register undefined until first programmed
// - controller holds idle command during power-on
// - controller waits 200 us, then precharges all
// - controller holds masks, clock gate high
// - mode set follows the initial precharge
// - eight auto refreshes, before or after
// - mode set needs precharged banks, gate high
// - mode set is all four strobes low
// - address lines load mode register parameters
// - wait recovery time after mode set
module sdc_dram_end
    import sdc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    sdc_if.dram mem,
    output logic [ADDR_W-1:0] modeParams,
    output logic modeValid,
    output sdc_pwr_t powerState,
    output logic [BANKS-1:0] bankOpen,
    output logic [REFRESH_CNT_W-1:0] refreshCount
);
    typedef struct packed {
        logic [ADDR_W-1:0] modeParams;
        logic modeValid;
        logic [BANKS-1:0] bankOpen;
        logic [BANKS-1:0][ADDR_W-1:0] openRow;
        sdc_pwr_t pwr;
        logic burstRead;
        logic burstWrite;
        logic [COL_W-1:0] burstStart;
        logic [COL_W-1:0] burstCnt;
        logic burstBank;
        logic burstAutoPre;
        logic [1:0] pipeValid;
        logic [1:0][MEM_AW-1:0] pipeAddr;
        logic [BYTES-1:0] maskQ;
        logic [DATA_W-1:0] dqOut;
        logic [BYTES-1:0] dqOe;
        logic [RCV_W-1:0] recovery;
        logic [REFRESH_CNT_W-1:0] refreshCount;
    } sdc_dram_state_t;

    sdc_dram_state_t state_q;
    sdc_dram_state_t state_d;
    sdc_cmd_t cmd;
    logic cmdOk;
    logic beatOn;
    logic beatIsWrite;
    logic beatBank;
    logic [COL_W-1:0] beatIdx;
    logic [COL_W-1:0] startCol;
    logic [COL_W-1:0] beatCol;
    logic [COL_W-1:0] lenMask;
    logic [BYTES-1:0] wrByte;
    logic [MEM_AW-1:0] tapAddr;
    logic tapValid;
    logic [DATA_W-1:0] rdWord;

    function automatic logic [COL_W-1:0] len_mask(input logic [MODE_BL_W-1:0] code);
        unique case (code)
            BL_TWO: return 8'h01;
            BL_FOUR: return 8'h03;
            BL_EIGHT: return 8'h07;
            BL_PAGE: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction

    assign cmd = sdc_cmd_t'({mem.rowStrobeN, mem.columnStrobeN, mem.writeStrobeN});
    assign lenMask = len_mask(state_q.modeParams[MODE_BL_LSB +: MODE_BL_W]);
    assign tapValid = (state_q.modeParams[MODE_CL_LSB +: MODE_CL_W] == CL_THREE)
        ? state_q.pipeValid[1] : state_q.pipeValid[0];
    assign tapAddr = (state_q.modeParams[MODE_CL_LSB +: MODE_CL_W] == CL_THREE)
        ? state_q.pipeAddr[1] : state_q.pipeAddr[0];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        cmdOk = 1'b0;
        beatOn = 1'b0;
        beatIsWrite = 1'b0;
        beatBank = 1'b0;
        beatIdx = '0;
        startCol = '0;
        beatCol = '0;
        wrByte = '0;
        if (state_q.pwr == PWR_SELF_REFRESH) begin
            if (mem.clockGateIn) begin
                state_d.pwr = PWR_ACTIVE;
            end
        end else if (!mem.clockGateIn) begin
            if (!mem.chipSelectN && cmd == CMD_AUTO_REFRESH) begin
                state_d.pwr = PWR_SELF_REFRESH;
            end else if (state_q.burstRead || state_q.burstWrite || (|state_q.pipeValid)) begin
                state_d.pwr = PWR_SUSPEND;
            end else begin
                state_d.pwr = PWR_DOWN;
            end
        end else begin
            state_d.pwr = PWR_ACTIVE;
            state_d.maskQ = {mem.upperByteMask, mem.lowerByteMask};
            // decoder gated by select and recovery
            cmdOk = !mem.chipSelectN && (state_q.recovery == '0);
            if (state_q.recovery != '0) begin
                state_d.recovery = state_q.recovery - 1'b1;
            end
            if (state_q.burstRead || state_q.burstWrite) begin
                beatOn = 1'b1;
                beatIsWrite = state_q.burstWrite;
                beatBank = state_q.burstBank;
                beatIdx = state_q.burstCnt;
                startCol = state_q.burstStart;
            end
            if (cmdOk) begin
                unique case (cmd)
                    CMD_MODE_SET: begin
                        state_d.modeParams = mem.addressLines;
                        state_d.modeValid = 1'b1;
                        state_d.recovery = RCV_W'(MODE_SET_RECOVERY_CYC - 1);
                        beatOn = 1'b0;
                    end
                    CMD_AUTO_REFRESH: begin
                        state_d.refreshCount = state_q.refreshCount + 1'b1;
                    end
                    CMD_PRECHARGE: begin
                        if (mem.addressLines[AUTO_PRECHARGE_BIT]) begin
                            state_d.bankOpen = '0;
                        end else begin
                            state_d.bankOpen[mem.bankSelect] = 1'b0;
                        end
                    end
                    CMD_ACTIVATE: begin
                        state_d.bankOpen[mem.bankSelect] = 1'b1;
                        state_d.openRow[mem.bankSelect] = mem.addressLines;
                    end
                    // column latch, needs mode and open bank
                    CMD_READ, CMD_WRITE: begin
                        if (state_q.modeValid && state_q.bankOpen[mem.bankSelect]) begin
                            beatOn = 1'b1;
                            beatIsWrite = (cmd == CMD_WRITE);
                            beatBank = mem.bankSelect;
                            beatIdx = '0;
                            startCol = mem.addressLines[COL_W-1:0];
                            state_d.burstStart = mem.addressLines[COL_W-1:0];
                            state_d.burstBank = mem.bankSelect;
                            state_d.burstAutoPre = mem.addressLines[AUTO_PRECHARGE_BIT];
                        end
                    end
                    CMD_BURST_STOP: begin
                        beatOn = 1'b0;
                    end
                    CMD_IDLE: begin
                        beatOn = beatOn;
                    end
                endcase
            end
            // burst wraps inside its length, no carry past it
            if (state_q.modeParams[MODE_BT_BIT] && lenMask != 8'hff) begin
                beatCol = (startCol & ~lenMask) | ((startCol ^ beatIdx) & lenMask);
            end else begin
                beatCol = (startCol & ~lenMask) | ((startCol + beatIdx) & lenMask);
            end
            state_d.burstRead = 1'b0;
            state_d.burstWrite = 1'b0;
            if (beatOn) begin
                state_d.burstCnt = beatIdx + 1'b1;
                if (beatIdx == lenMask) begin
                    if (state_d.burstAutoPre) begin
                        state_d.bankOpen[beatBank] = 1'b0;
                    end
                end else begin
                    state_d.burstRead = !beatIsWrite;
                    state_d.burstWrite = beatIsWrite;
                end
            end
            if (beatOn && beatIsWrite) begin
                wrByte = ~{mem.upperByteMask, mem.lowerByteMask};
            end
            state_d.pipeValid = {state_q.pipeValid[0], beatOn && !beatIsWrite};
            state_d.pipeAddr = {state_q.pipeAddr[0], {beatBank, beatCol}};
            // mask sampled one edge earlier, so hi-z lands two edges on
            state_d.dqOe = {BYTES{tapValid}} & ~state_q.maskQ;
            state_d.dqOut = rdWord;
        end
    end

    // state frozen while the clock enable is low
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= '0;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage holds one page per bank; the open row selects nothing
    for (genvar b = 0; b < BYTES; b++) begin : gLane
        logic [BYTE_W-1:0] laneMem [MEM_DEPTH];
        always_ff @(posedge ref_clk) begin
            if (nrst && clkEn && wrByte[b]) begin
                laneMem[{beatBank, beatCol}] <= mem.dataLines[b*BYTE_W +: BYTE_W];
            end
        end
        assign rdWord[b*BYTE_W +: BYTE_W] = laneMem[tapAddr];
    end

    assign mem.devData = state_q.dqOut;
    assign mem.devOe = state_q.dqOe;
    assign modeParams = state_q.modeParams;
    assign modeValid = state_q.modeValid;
    assign powerState = state_q.pwr;
    assign bankOpen = state_q.bankOpen;
    assign refreshCount = state_q.refreshCount;
endmodule // sdc_dram_end
`default_nettype wire

// ===== sdc_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sdc_asserts
    import sdc_pkg::*;
#(
    parameter int PAUSE_CYC = POWERUP_PAUSE_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic chipSelectN,
    input wire logic rowStrobeN,
    input wire logic columnStrobeN,
    input wire logic writeStrobeN,
    input wire logic clockGateIn,
    input wire logic [ADDR_W-1:0] addressLines,
    input wire logic upperByteMask,
    input wire logic lowerByteMask,
    input wire logic [BYTES-1:0] devOe,
    input wire logic [DATA_W-1:0] devData
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sdc_cmd_t cmdNow;
    logic [15:0] age_q;
    logic pre_q;
    logic [3:0] ref_q;
    // a deselected cycle counts as idle
    assign cmdNow = chipSelectN ? CMD_IDLE : sdc_cmd_t'({rowStrobeN, columnStrobeN, writeStrobeN});
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            age_q <= 16'h0000;
            pre_q <= 1'b0;
            ref_q <= 4'h0;
        end else begin
            age_q <= (age_q == 16'hffff) ? age_q : age_q + 16'h0001;
            pre_q <= pre_q | (cmdNow == CMD_PRECHARGE);
            ref_q <= (cmdNow == CMD_AUTO_REFRESH && ref_q != 4'hf) ? ref_q + 4'h1 : ref_q;
        end
    end
    ////////////////////////////////////////
    sequence maskSeen(m);
        m && clockGateIn ##1 clockGateIn;
    endsequence
    a_mask_lower_lane: assert property (maskSeen(lowerByteMask) |=> !devOe[0])
        else $error("lower lane driven two edges after mask");
    a_mask_upper_lane: assert property (maskSeen(upperByteMask) |=> !devOe[1])
        else $error("upper lane driven two edges after mask");
    a_gate_freezes_data: assert property (!clockGateIn |=> $stable(devOe) && $stable(devData))
        else $error("data pins moved with clock gate low");
    // the edge of slack covers a timer that loads on the reset edge
    a_pause_held_idle: assert property ((age_q < PAUSE_CYC - 1) |->
        cmdNow == CMD_IDLE && lowerByteMask && upperByteMask && clockGateIn)
        else $error("pins not idle during power-up pause");
    a_first_is_precharge: assert property ((cmdNow != CMD_IDLE && !pre_q) |->
        cmdNow == CMD_PRECHARGE && addressLines[AUTO_PRECHARGE_BIT] && age_q >= PAUSE_CYC - 1)
        else $error("first command not a precharge of all banks after pause");
    a_mode_after_pre: assert property (cmdNow == CMD_MODE_SET |-> pre_q)
        else $error("mode set before any precharge");
    a_refresh_before_use: assert property (cmdNow inside {CMD_ACTIVATE, CMD_READ, CMD_WRITE} |-> ref_q >= 4'h8)
        else $error("access before eight refreshes");
    a_mode_gate_high: assert property (cmdNow == CMD_MODE_SET |-> clockGateIn && $past(clockGateIn))
        else $error("mode set without gate high a cycle before");
    a_mode_recovery_idle: assert property (cmdNow == CMD_MODE_SET |=> cmdNow == CMD_IDLE)
        else $error("command inside mode set recovery");
endmodule // sdc_asserts
`default_nettype wire

// ===== sdram_cmd_pins_and_init_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module sdram_cmd_pins_and_init_test
    import sdc_pkg::*;
;
    // short pause keeps the run small
    localparam int PAUSE = 20;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic clkEn = 1'b1;
    logic reqValid = 1'b0;
    sdc_cmd_t reqCmd = CMD_IDLE;
    logic reqBank = 1'b0;
    logic [ADDR_W-1:0] reqAddr = 11'h000;
    logic userCke = 1'b1;
    logic [BYTES-1:0] userMask = 2'h0;
    logic [BYTES-1:0] userDrive = 2'h0;
    logic [DATA_W-1:0] userWdata = 16'h0000;
    logic [ADDR_W-1:0] modeValue = 11'h020;
    logic reqReady;
    logic initDone;
    logic [DATA_W-1:0] readData;
    logic [ADDR_W-1:0] modeParams;
    logic modeValid;
    sdc_pwr_t powerState;
    logic [BANKS-1:0] bankOpen;
    logic [REFRESH_CNT_W-1:0] refreshCount;
    int bad_count = 0;
    int tests_run = 0;
    sdc_if memIf();
    sdc_ctrl_end #(.PAUSE_CYC(PAUSE)) sdc_ctrl_end_inst (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .mem(memIf),
        .modeValue(modeValue), .reqValid(reqValid), .reqCmd(reqCmd), .reqBank(reqBank), .reqAddr(reqAddr),
        .userCke(userCke), .userMask(userMask), .userDrive(userDrive), .userWdata(userWdata),
        .reqReady(reqReady), .initDone(initDone), .readData(readData));
    sdc_dram_end sdc_dram_end_inst (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .mem(memIf),
        .modeParams(modeParams), .modeValid(modeValid), .powerState(powerState), .bankOpen(bankOpen),
        .refreshCount(refreshCount));
    sdc_asserts #(.PAUSE_CYC(PAUSE)) sdc_asserts_inst (.ref_clk(ref_clk), .nrst(nrst),
        .chipSelectN(memIf.chipSelectN), .rowStrobeN(memIf.rowStrobeN), .columnStrobeN(memIf.columnStrobeN),
        .writeStrobeN(memIf.writeStrobeN), .clockGateIn(memIf.clockGateIn), .addressLines(memIf.addressLines),
        .upperByteMask(memIf.upperByteMask), .lowerByteMask(memIf.lowerByteMask), .devOe(memIf.devOe),
        .devData(memIf.devData));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ends two edges after acceptance: the far end has latched the command and its outputs have settled
    task automatic req(input sdc_cmd_t c, input logic b, input logic [ADDR_W-1:0] a);
        int n;
        n = 0;
        reqValid <= 1'b1;
        reqCmd <= c;
        reqBank <= b;
        reqAddr <= a;
        do begin
            @(posedge ref_clk);
            n++;
        end while (reqReady !== 1'b1 && n < 600);
        if (reqReady !== 1'b1) begin
            bad_count++;
            $display("[ERR] request wait ran out");
            tally_and_finish();
        end
        reqValid <= 1'b0;
        @(posedge ref_clk);
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic b, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] m);
        userDrive <= 2'h3;
        userWdata <= d;
        userMask <= m;
        req(CMD_WRITE, b, a);
    endtask
    task automatic rd(input logic b, input logic [ADDR_W-1:0] a, input logic [1:0] m, input logic [DATA_W-1:0] e);
        userDrive <= 2'h0;
        userMask <= m;
        req(CMD_READ, b, a);
        userMask <= 2'h0;
        repeat (2) @(posedge ref_clk);
        `CHK("readData", e, readData)
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        req(CMD_IDLE, 1'b0, 11'h000);
        `CHK("initDone", 1'b1, initDone)
        `CHK("refreshCount", 8'h08, refreshCount)
        `CHK("modeParams", 11'h020, modeParams)
        `CHK("modeValid", 1'b1, modeValid)
        req(CMD_ACTIVATE, 1'b0, 11'h005);
        req(CMD_ACTIVATE, 1'b1, 11'h7ff);
        `CHK("bankOpen", 2'h3, bankOpen)
        wr(1'b0, 11'h010, 16'ha5c3, 2'h0);
        wr(1'b1, 11'h010, 16'h1234, 2'h0);
        wr(1'b0, 11'h011, 16'hbeef, 2'h0);
        wr(1'b0, 11'h011, 16'h1122, 2'h2);
        rd(1'b0, 11'h310, 2'h0, 16'ha5c3);
        rd(1'b1, 11'h010, 2'h0, 16'h1234);
        rd(1'b0, 11'h011, 2'h0, 16'hbe22);
        rd(1'b0, 11'h010, 2'h1, 16'ha500);
        rd(1'b0, 11'h010, 2'h2, 16'h00c3);
        clkEn <= 1'b0;
        userCke <= 1'b0;
        repeat (5) @(posedge ref_clk);
        `CHK("powerState", PWR_ACTIVE, powerState)
        clkEn <= 1'b1;
        repeat (5) @(posedge ref_clk);
        `CHK("powerState", PWR_DOWN, powerState)
        userCke <= 1'b1;
        repeat (5) @(posedge ref_clk);
        `CHK("powerState", PWR_ACTIVE, powerState)
        req(CMD_PRECHARGE, 1'b0, 11'h400);
        `CHK("bankOpen", 2'h0, bankOpen)
        req(CMD_MODE_SET, 1'b0, 11'h031);
        `CHK("modeParams", 11'h031, modeParams)
        req(CMD_ACTIVATE, 1'b0, 11'h005);
        rd(1'b0, 11'h010, 2'h0, 16'h0000);
        @(posedge ref_clk);
        `CHK("readData", 16'ha5c3, readData)
        @(posedge ref_clk);
        `CHK("readData", 16'hbe22, readData)
        tally_and_finish();
    end
endmodule // sdram_cmd_pins_and_init_test
`default_nettype wire
